// ==== sqcr_amp_model.sv ====
// Behavioural model of the attached sensor amplifier
`timescale 1ns/1ns
module sqcr_amp_model (
  // Clock
  input  wire logic        i_ref_clk,
  // Query from the responder
  input  wire logic        i_req,
  // Level to return and reply delay
  input  wire logic [31:0] i_src,
  input  wire logic [3:0]  i_dly,
  // Reply
  output logic             o_ack,
  output logic      [31:0] o_level
);
  logic [3:0]  cnt_reg  = 4'h0;
  logic [31:0] last_reg = 32'h0;

  initial o_ack = 1'b0;
  initial o_level = 32'h0;

  // Reply after a chosen delay; level is only valid beside the ack pulse
  always @(posedge i_ref_clk) begin
    if (!i_req || o_ack) begin
      cnt_reg <= 4'h0;
      o_ack   <= 1'b0;
      o_level <= ~last_reg;  // Released lines show garbage, not the old value
    end else if (cnt_reg == i_dly) begin
      o_ack    <= 1'b1;
      o_level  <= i_src;
      last_reg <= i_src;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      o_level <= ~last_reg;
    end
  end
endmodule

// ==== sqcr_defs.svh ====
// Constants of the sensor query command responder
`ifndef SQCR_DEFS_SVH
`define SQCR_DEFS_SVH
// Command codes
`define SQCR_CMD_SW_VERSION  8'h0b
`define SQCR_CMD_UNIT_ID     8'h0c
`define SQCR_CMD_DETECT      8'h20
`define SQCR_CMD_PEAK        8'h22
`define SQCR_CMD_BOTTOM      8'h24
`define SQCR_CMD_ZERO_RESET  8'h27
`define SQCR_CMD_STATUS      8'h28
// Result codes
`define SQCR_RES_OK          16'h0000
`define SQCR_RES_BAD_CMD     16'h0001
// Register offsets
`define SQCR_OFS_CMD         8'h00
`define SQCR_OFS_CTRL        8'h04
`define SQCR_OFS_RESULT      8'h08
`define SQCR_OFS_DATA1       8'h0c
`define SQCR_OFS_DATA2       8'h10
`define SQCR_OFS_IRQ_STAT    8'h14
`define SQCR_OFS_IRQ_EN      8'h18
`define SQCR_OFS_IRQ_CLR     8'h1c
// Field positions
`define SQCR_CTRL_REQ_BIT    0
`define SQCR_CTRL_DONE_BIT   1
`define SQCR_STS_NORMAL      0
`define SQCR_STS_APC1        1
`define SQCR_STS_TUNE1       2
`define SQCR_STS_APC2        3
`define SQCR_STS_TUNE2       4
`define SQCR_STS_APC_ERR     8
`define SQCR_STS_NVM_ERR     9
`define SQCR_STS_SHORT_ERR   10
`define SQCR_STS_HEAD_ERR    11
// Interrupt bits
`define SQCR_IRQ_DONE_BIT    0
`define SQCR_IRQ_FAULT_BIT   1
// Reset values
`define SQCR_RST_WORD        16'h0000
`define SQCR_RST_IRQ         2'h0
// Zero-reset level limits
`define SQCR_ZR_MIN_NARROW   (-32'sd9999)
`define SQCR_ZR_MIN_WIDE     (-32'sd999999999)
`endif

// ==== sqcr_level_clamp.sv ====
// Clamp of the zero-reset level to its documented range
`timescale 1ns/1ns
`include "sqcr_defs.svh"
module sqcr_level_clamp (
  // Raw level and range select
  input  wire logic signed [31:0] i_level,
  input  wire logic               i_wide,
  // Clamped level
  output logic signed      [31:0] o_level
);
  logic signed [31:0] lo;
  // Level never goes above zero nor below the type's floor
  always_comb begin
    lo = i_wide ? `SQCR_ZR_MIN_WIDE : `SQCR_ZR_MIN_NARROW;
    if (i_level > 32'sd0) begin
      o_level = 32'sd0;
    end else if (i_level < lo) begin
      o_level = lo;
    end else begin
      o_level = i_level;
    end
  end
endmodule

// ==== sqcr_pkg.sv ====
// Types of the sensor query command responder
package sqcr_pkg;
  typedef enum logic [3:0] {
    SQCR_IDLE  = 4'b0001,
    SQCR_FETCH = 4'b0010,
    SQCR_DONE  = 4'b0100,
    SQCR_DROP  = 4'b1000
  } sqcr_state_t;
endpackage

// ==== sqcr_responder.sv ====
// Sensor query command responder: register port, handshake and answers
// Notes on behaviour
// - Request starts fetch; done raised with result
// - Dropping request drops completion flag
// - Version query returns binary firmware version
// - Identity query returns unit identifier
// - Zero-reset level clamped to type range
// - Status query returns bit-mapped flag word
// - Normal bit cleared by any fault
// - Bit 1: first channel power control
// - Bit 2: first channel auto tuning
// - Bit 3: second channel power control
// - Bit 4: second channel auto tuning
// - Bits 5 to 7 read zero
// - Bit 8: power control fault
// - Bit 9: memory response or checksum fault
// - Bit 10: output load short
// - Bit 11: sensing head fault
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "sqcr_defs.svh"
module sqcr_responder #(
  parameter logic [15:0] FW_VERSION = 16'h0100,  // Arbitrary value
  parameter logic [31:0] UNIT_ID    = 32'h5a5a0001  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Amplifier side
  output logic             o_amp_req,
  output logic      [7:0]  o_amp_cmd,
  input  wire logic        i_amp_ack,
  input  wire logic [31:0] i_amp_level,
  input  wire logic        i_amp_wide,
  // Amplifier conditions
  input  wire logic        i_apc1_active,
  input  wire logic        i_tune1_active,
  input  wire logic        i_apc2_active,
  input  wire logic        i_tune2_active,
  input  wire logic        i_two_channel,
  input  wire logic        i_apc_fault,
  input  wire logic        i_nvm_resp_fault,
  input  wire logic        i_nvm_sum_fault,
  input  wire logic        i_short_fault,
  input  wire logic        i_head_fault,
  // Interrupt
  output logic             o_irq
);
  sqcr_pkg::sqcr_state_t state_reg;
  logic [7:0]  command_code_word_reg;
  logic        req_reg;
  logic        done_reg;
  logic [15:0] result_reg;
  logic [15:0] received_data_first_word_reg;
  logic [15:0] received_data_second_word_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_en_reg;
  logic [15:0] status_word;
  logic [31:0] zr_level;
  logic [31:0] answer;
  logic        bad_cmd;
  logic        needs_amp;
  logic        done_evt;
  logic        fault_evt;
  logic        fault_any_d_reg;

  // True for command codes that go out to the amplifier
  function automatic logic is_amp_cmd(input logic [7:0] c);
    is_amp_cmd = (c == `SQCR_CMD_DETECT) || (c == `SQCR_CMD_PEAK) ||
                 (c == `SQCR_CMD_BOTTOM) || (c == `SQCR_CMD_ZERO_RESET) ||
                 (c == `SQCR_CMD_STATUS);
  endfunction

  sqcr_status_word u_status (
    .i_apc1_active    (i_apc1_active),
    .i_tune1_active   (i_tune1_active),
    .i_apc2_active    (i_apc2_active),
    .i_tune2_active   (i_tune2_active),
    .i_two_channel    (i_two_channel),
    .i_apc_fault      (i_apc_fault),
    .i_nvm_resp_fault (i_nvm_resp_fault),
    .i_nvm_sum_fault  (i_nvm_sum_fault),
    .i_short_fault    (i_short_fault),
    .i_head_fault     (i_head_fault),
    .o_status         (status_word)
  );

  sqcr_level_clamp u_clamp (
    .i_level (i_amp_level),
    .i_wide  (i_amp_wide),
    .o_level (zr_level)
  );

  assign needs_amp = is_amp_cmd(command_code_word_reg);
  assign bad_cmd   = !needs_amp && (command_code_word_reg != `SQCR_CMD_SW_VERSION) &&
                     (command_code_word_reg != `SQCR_CMD_UNIT_ID);

  // Answer selection; peak and bottom pass through, display mode is the host's job
  always_comb begin
    answer = 32'h0000_0000;
    if (command_code_word_reg == `SQCR_CMD_SW_VERSION) begin
      answer = {16'h0000, FW_VERSION};
    end else if (command_code_word_reg == `SQCR_CMD_UNIT_ID) begin
      answer = UNIT_ID;
    end else if (command_code_word_reg == `SQCR_CMD_ZERO_RESET) begin
      answer = zr_level;
    end else if (command_code_word_reg == `SQCR_CMD_STATUS) begin
      answer = {16'h0000, status_word};
    end else if (needs_amp) begin
      answer = i_amp_level;
    end
  end

  // Handshake state machine
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state_reg <= sqcr_pkg::SQCR_IDLE;
    end else begin
      case (state_reg)
        sqcr_pkg::SQCR_IDLE: begin
          if (req_reg) begin
            state_reg <= sqcr_pkg::SQCR_FETCH;
          end
        end
        sqcr_pkg::SQCR_FETCH: begin
          if (!needs_amp || i_amp_ack) begin
            state_reg <= sqcr_pkg::SQCR_DONE;
          end
        end
        sqcr_pkg::SQCR_DONE: begin
          if (!req_reg) begin
            state_reg <= sqcr_pkg::SQCR_IDLE;
          end
        end
        default: begin
          state_reg <= sqcr_pkg::SQCR_IDLE;
        end
      endcase
    end
  end

  assign done_evt = (state_reg == sqcr_pkg::SQCR_FETCH) && (!needs_amp || i_amp_ack);

  // Completion flag follows the handshake
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      done_reg <= 1'b0;
    end else if (done_evt) begin
      done_reg <= 1'b1;
    end else if (state_reg == sqcr_pkg::SQCR_DONE && !req_reg) begin
      done_reg <= 1'b0;
    end
  end

  // Response words captured once, so they stay stable while the host reads them
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      result_reg                    <= `SQCR_RST_WORD;
      received_data_first_word_reg  <= `SQCR_RST_WORD;
      received_data_second_word_reg <= `SQCR_RST_WORD;
    end else if (done_evt) begin
      result_reg                    <= bad_cmd ? `SQCR_RES_BAD_CMD : `SQCR_RES_OK;
      received_data_first_word_reg  <= answer[15:0];
      received_data_second_word_reg <= answer[31:16];
    end
  end

  // Amplifier request lines
  assign o_amp_req = (state_reg == sqcr_pkg::SQCR_FETCH) && needs_amp;
  assign o_amp_cmd = command_code_word_reg;

  // Host-written command and request; command frozen while busy
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      command_code_word_reg <= 8'h00;
      req_reg               <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == `SQCR_OFS_CMD && state_reg == sqcr_pkg::SQCR_IDLE) begin
        command_code_word_reg <= i_wdata[7:0];
      end else if (i_addr == `SQCR_OFS_CTRL) begin
        req_reg <= i_wdata[`SQCR_CTRL_REQ_BIT];
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      irq_en_reg <= `SQCR_RST_IRQ;
    end else if (i_wr && i_addr == `SQCR_OFS_IRQ_EN) begin
      irq_en_reg <= i_wdata[1:0];
    end
  end

  // Fault event is the rising edge of the not-normal condition
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      fault_any_d_reg <= 1'b0;
    end else begin
      fault_any_d_reg <= ~status_word[`SQCR_STS_NORMAL];
    end
  end
  assign fault_evt = ~status_word[`SQCR_STS_NORMAL] & ~fault_any_d_reg;

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      irq_stat_reg <= `SQCR_RST_IRQ;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((i_wr && i_addr == `SQCR_OFS_IRQ_CLR) ? i_wdata[1:0] : 2'h0))
                      | {fault_evt, done_evt};
    end
  end
  assign o_irq = |(irq_stat_reg & irq_en_reg);

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      if (i_addr == `SQCR_OFS_CMD) begin
        o_rdata <= {24'h000000, command_code_word_reg};
      end else if (i_addr == `SQCR_OFS_CTRL) begin
        o_rdata <= {30'h0, done_reg, req_reg};
      end else if (i_addr == `SQCR_OFS_RESULT) begin
        o_rdata <= {16'h0000, result_reg};
      end else if (i_addr == `SQCR_OFS_DATA1) begin
        o_rdata <= {16'h0000, received_data_first_word_reg};
      end else if (i_addr == `SQCR_OFS_DATA2) begin
        o_rdata <= {16'h0000, received_data_second_word_reg};
      end else if (i_addr == `SQCR_OFS_IRQ_STAT) begin
        o_rdata <= {30'h0, irq_stat_reg};
      end else if (i_addr == `SQCR_OFS_IRQ_EN) begin
        o_rdata <= {30'h0, irq_en_reg};
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // Completion rises within two cycles of request for local commands
  chk_done_local: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state_reg == sqcr_pkg::SQCR_IDLE && req_reg && !needs_amp) |-> ##[1:2] done_reg)
    else $error("completion flag not raised");

  // Completion drops within two cycles after request drops
  chk_done_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (done_reg && !req_reg) |-> ##[1:2] !done_reg)
    else $error("completion flag stuck high");

  // Normal bit is the inverse of any fault bit
  chk_normal_bit: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    status_word[`SQCR_STS_NORMAL] == !(|status_word[15:8]))
    else $error("normal bit wrong");

  // Unused bits 5 to 7 never set
  chk_unused_bits: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    status_word[7:5] == 3'h0)
    else $error("unused status bits set");

  // Zero-reset level never positive
  chk_zr_range: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $signed(zr_level) <= 32'sd0)
    else $error("zero-reset level positive");

  // Version answer lands in the first word
  chk_version_word: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (done_evt && command_code_word_reg == `SQCR_CMD_SW_VERSION) |=> received_data_first_word_reg == FW_VERSION)
    else $error("version word wrong");

  // Identity answer split over both words
  chk_id_words: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (done_evt && command_code_word_reg == `SQCR_CMD_UNIT_ID)
    |=> {received_data_second_word_reg, received_data_first_word_reg} == UNIT_ID)
    else $error("identity words wrong");

  // Level words lower first
  chk_level_order: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (done_evt && command_code_word_reg == `SQCR_CMD_DETECT)
    |=> received_data_second_word_reg == $past(i_amp_level[31:16]))
    else $error("level word order wrong");

  // Second-channel flags held low on one-channel types
  chk_ch2_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !i_two_channel |-> status_word[4:3] == 2'h0)
    else $error("second channel flag on single channel type");

  // Status answer copies the live status word
  chk_status_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (done_evt && command_code_word_reg == `SQCR_CMD_STATUS) |=> received_data_first_word_reg == $past(status_word))
    else $error("status answer wrong");
endmodule

// ==== sqcr_status_word.sv ====
// Bit-mapped sensor status word builder
`timescale 1ns/1ns
`include "sqcr_defs.svh"
module sqcr_status_word (
  // Amplifier condition inputs
  input  wire logic        i_apc1_active,
  input  wire logic        i_tune1_active,
  input  wire logic        i_apc2_active,
  input  wire logic        i_tune2_active,
  input  wire logic        i_two_channel,
  input  wire logic        i_apc_fault,
  input  wire logic        i_nvm_resp_fault,
  input  wire logic        i_nvm_sum_fault,
  input  wire logic        i_short_fault,
  input  wire logic        i_head_fault,
  // Status word
  output logic      [15:0] o_status
);
  // Flags follow conditions; second channel only counts on two-channel types
  always_comb begin
    o_status = 16'h0000;
    o_status[`SQCR_STS_APC1]      = i_apc1_active;
    o_status[`SQCR_STS_TUNE1]     = i_tune1_active;
    o_status[`SQCR_STS_APC2]      = i_apc2_active & i_two_channel;
    o_status[`SQCR_STS_TUNE2]     = i_tune2_active & i_two_channel;
    o_status[`SQCR_STS_APC_ERR]   = i_apc_fault;
    o_status[`SQCR_STS_NVM_ERR]   = i_nvm_resp_fault | i_nvm_sum_fault;
    o_status[`SQCR_STS_SHORT_ERR] = i_short_fault;
    o_status[`SQCR_STS_HEAD_ERR]  = i_head_fault;
    o_status[`SQCR_STS_NORMAL]    = ~(|o_status[15:8]);
  end
endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the sensor query command responder
`timescale 1ns/1ns
`include "sqcr_defs.svh"
module tb_top;
  localparam logic [15:0] FW  = 16'h0203;      // Arbitrary value
  localparam logic [31:0] UID = 32'h1234abcd;  // Arbitrary value

  logic        i_ref_clk   = 1'b0;
  logic        i_rstn      = 1'b0;
  logic [7:0]  i_addr      = 8'h00;
  logic [31:0] i_wdata     = 32'h0;
  logic        i_wr        = 1'b0;
  logic        i_rd        = 1'b0;
  logic        i_amp_wide  = 1'b0;
  logic [9:0]  cond        = 10'h000;
  logic [31:0] amp_src     = 32'h0;
  logic [3:0]  amp_dly     = 4'h0;
  logic [31:0] o_rdata;
  logic        o_amp_req;
  logic [7:0]  o_amp_cmd;
  logic        i_amp_ack;
  logic [31:0] i_amp_level;
  logic        o_irq;
  logic [31:0] rv;
  int          failures    = 0;
  int          tests_run   = 0;
  int          cycles      = 0;
  logic [31:0] zr_in  [4] = '{32'hffffb1e0, 32'h00000005, 32'hc4653600, 32'hffffb1e0};
  logic        zr_wide[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [31:0] zr_exp [4] = '{32'hffffd8f1, 32'h00000000, 32'hc4653601, 32'hffffb1e0};

  sqcr_responder #(.FW_VERSION(FW), .UNIT_ID(UID)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_amp_req(o_amp_req), .o_amp_cmd(o_amp_cmd),
    .i_amp_ack(i_amp_ack), .i_amp_level(i_amp_level), .i_amp_wide(i_amp_wide),
    .i_apc1_active(cond[0]), .i_tune1_active(cond[1]), .i_apc2_active(cond[2]),
    .i_tune2_active(cond[3]), .i_apc_fault(cond[4]), .i_two_channel(cond[5]),
    .i_nvm_resp_fault(cond[6]), .i_nvm_sum_fault(cond[7]), .i_short_fault(cond[8]),
    .i_head_fault(cond[9]), .o_irq(o_irq));

  sqcr_amp_model amp_u (
    .i_ref_clk(i_ref_clk), .i_req(o_amp_req), .i_src(amp_src), .i_dly(amp_dly),
    .o_ack(i_amp_ack), .o_level(i_amp_level));

  // 20 MHz clock
  always #25 i_ref_clk = ~i_ref_clk;

  // Hang guard; the whole run needs under a thousand cycles
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // Poll the completion flag under a bounded count
  task automatic wait_done(input logic want);
    logic [31:0] c;
    int n;
    n = 0;
    do begin
      rd(`SQCR_OFS_CTRL, c);
      n++;
    end while (c[1] !== want && n < 40);
    chk_bit(c[1], want);
  endtask

  // One full command: load, request, poll, check words, release
  task automatic query(input logic [7:0] cmd, input logic [15:0] res, input logic [31:0] val);
    logic [31:0] d;
    wr(`SQCR_OFS_CMD, {24'h0, cmd});
    wr(`SQCR_OFS_CTRL, 32'h1);
    wait_done(1'b1);
    chk_word({24'h0, o_amp_cmd}, {24'h0, cmd});
    chk_bit(o_amp_req, 1'b0);
    wr(`SQCR_OFS_CMD, {24'h0, ~cmd});  // Busy, so this write must be ignored
    rd(`SQCR_OFS_CMD, d);
    chk_word(d, {24'h0, cmd});
    rd(`SQCR_OFS_RESULT, d);
    chk_word(d, {16'h0, res});
    rd(`SQCR_OFS_DATA1, d);
    chk_word(d, {16'h0, val[15:0]});
    rd(`SQCR_OFS_DATA2, d);
    chk_word(d, {16'h0, val[31:16]});
    wr(`SQCR_OFS_CTRL, 32'h0);
    wait_done(1'b0);
  endtask

  // Status word worked out from the condition levels
  function automatic logic [15:0] exp_status(input logic [9:0] c);
    logic [15:0] s;
    s     = 16'h0;
    s[1]  = c[0];
    s[2]  = c[1];
    s[3]  = c[2] & c[5];
    s[4]  = c[3] & c[5];
    s[8]  = c[4];
    s[9]  = c[6] | c[7];
    s[10] = c[8];
    s[11] = c[9];
    s[0]  = ~|s[15:8];
    return s;
  endfunction

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rd(`SQCR_OFS_CTRL, rv);
    chk_word(rv, 32'h0);
    rd(8'h40, rv);
    chk_word(rv, 32'h0);
    chk_bit(o_irq, 1'b0);
    // Done event raises, mask and clear the interrupt
    wr(`SQCR_OFS_IRQ_EN, 32'h1);
    query(`SQCR_CMD_SW_VERSION, `SQCR_RES_OK, {16'h0, FW});
    rd(`SQCR_OFS_IRQ_STAT, rv);
    chk_word(rv, 32'h1);
    chk_bit(o_irq, 1'b1);
    wr(`SQCR_OFS_IRQ_EN, 32'h0);
    rd(`SQCR_OFS_IRQ_STAT, rv);
    chk_bit(o_irq, 1'b0);
    wr(`SQCR_OFS_IRQ_CLR, 32'h1);
    rd(`SQCR_OFS_IRQ_STAT, rv);
    chk_word(rv, 32'h0);
    // Fault edge sets the second event bit
    wr(`SQCR_OFS_IRQ_EN, 32'h2);
    cond <= 10'h100;
    rd(`SQCR_OFS_IRQ_STAT, rv);
    chk_word(rv, 32'h2);
    chk_bit(o_irq, 1'b1);
    cond <= 10'h000;
    wr(`SQCR_OFS_IRQ_CLR, 32'h3);
    rd(`SQCR_OFS_IRQ_STAT, rv);
    chk_word(rv, 32'h0);
    chk_bit(o_irq, 1'b0);
    query(`SQCR_CMD_UNIT_ID, `SQCR_RES_OK, UID);
    query(8'h55, `SQCR_RES_BAD_CMD, 32'h0);
    // Amplifier levels, prompt and slow replies
    amp_src <= 32'hfffff831;
    amp_dly <= 4'h9;
    query(`SQCR_CMD_DETECT, `SQCR_RES_OK, 32'hfffff831);
    amp_src <= 32'h0000270f;
    amp_dly <= 4'h0;
    query(`SQCR_CMD_PEAK, `SQCR_RES_OK, 32'h0000270f);  // Display select assumed set
    amp_src <= 32'hffffffff;
    query(`SQCR_CMD_BOTTOM, `SQCR_RES_OK, 32'hffffffff);  // Display select assumed set
    for (int i = 0; i < 4; i++) begin
      amp_src    <= zr_in[i];
      i_amp_wide <= zr_wide[i];
      query(`SQCR_CMD_ZERO_RESET, `SQCR_RES_OK, zr_exp[i]);
    end
    // Each condition alone, then all channel flags on a two-channel type
    for (int i = 0; i < 11; i++) begin
      cond <= (i < 10) ? (10'h001 << i) : 10'h02f;
      query(`SQCR_CMD_STATUS, `SQCR_RES_OK, {16'h0, exp_status((i < 10) ? (10'h001 << i) : 10'h02f)});
    end
    results();
  end
endmodule
